// ===== inc/smp_defs.svh
// Register map, field positions, reset values and timing constants of the serial port
// What this block does
// RULE_01 - Enabled master starts a full-duplex transfer when the data register is written.
// RULE_02 - Completion flag sets itself at transfer end, stays until software clears it.
// RULE_03 - Slave shifts data register out and serial input in on master clocks.
// RULE_04 - Master asserts active-low select before giving any serial clock edge.
// RULE_05 - Slave output data is valid before the first capturing edge.
// RULE_06 - Port keeps working while its selected clock source runs.
// RULE_07 - Link opens with select control on, select low, then data write starts master.
// RULE_08 - Disabled port releases clock, data in, data out and select pins.
// RULE_09 - Transfers use clock, data in and data out lines, plus the select line when select control is set.
// RULE_10 - Select control cleared: select pin floats and is ignored.
// RULE_11 - Select control on and idle: data input floats, data output driven high; a slave drives the first bit of its buffer instead.
// RULE_12 - Master idle clock level follows the clock polarity setting.
// RULE_13 - Slave leaves its serial clock pin floating as input while idle.
// RULE_14 - Only the master makes the serial clock, after a data register write.
// RULE_15 - Configure mode and clock, then select control and bit order, then enable.
// RULE_16 - Received bits gather in a shift buffer, copied to data register when complete.
// RULE_17 - Data write during transfer is dropped and sets the sticky collision flag.
// RULE_18 - Completion raises an interrupt request for polling or interrupt use.
// RULE_19 - Three-bit mode picks divide 4, 16, 64, sub clock, timer half, slave, off.
// RULE_20 - Polarity 0 idles high, edge bit picks rising/falling; polarity 1 inverts both.
// RULE_21 - Slave select rising before completion sets incomplete and completion flags.
// RULE_22 - Bit order set shifts MSB first, cleared shifts LSB first.
// RULE_23 - Each transfer moves exactly eight bits per direction.
`ifndef SMP_DEFS_SVH
`define SMP_DEFS_SVH
`define SMP_CTRL0_ADDR     8'h00
`define SMP_CTRL1_ADDR     8'h04
`define SMP_DATA_ADDR      8'h08
`define SMP_CTRL0_RESET    8'he0
`define SMP_CTRL1_RESET    8'h00
`define SMP_C0_ROLE_HI     7
`define SMP_C0_ROLE_LO     5
`define SMP_C0_EN          1
`define SMP_C0_ICF         0
`define SMP_C1_POL         5
`define SMP_C1_EDGE        4
`define SMP_C1_MSB         3
`define SMP_C1_CSEN        2
`define SMP_C1_WCOL        1
`define SMP_C1_TRF         0
`define SMP_DIV4_HALF      8'd2
`define SMP_DIV16_HALF     8'd8
`define SMP_DIV64_HALF     8'd32
`define SMP_BITS           4'd8
`endif

// ===== inc/smp_pkg.sv
// Types shared by the serial port design
package smp_pkg;
  typedef enum logic [2:0] {
    SMP_ROLE_DIV4  = 3'b000,
    SMP_ROLE_DIV16 = 3'b001,
    SMP_ROLE_DIV64 = 3'b010,
    SMP_ROLE_SUB   = 3'b011,
    SMP_ROLE_TMR   = 3'b100,
    SMP_ROLE_SLAVE = 3'b101,
    SMP_ROLE_OFF0  = 3'b110,
    SMP_ROLE_OFF1  = 3'b111
  } smp_role_type;
  typedef enum logic [1:0] {
    SMP_ST_IDLE  = 2'b00,
    SMP_ST_LEAD  = 2'b01,
    SMP_ST_SHIFT = 2'b10
  } smp_state_type;
endpackage

// ===== design/smp_port.sv
// Serial port master/slave with AHB-Lite register access
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "smp_defs.svh"
module smp_port (
  input  wire logic        clock_i,        // 20 MHz system clock
  input  wire logic        rst_n_i,        // Async reset, active low
  input  wire logic        hsel_i,         // AHB slave select
  input  wire logic [31:0] haddr_i,        // AHB address
  input  wire logic [1:0]  htrans_i,       // AHB transfer type
  input  wire logic        hwrite_i,       // AHB write
  input  wire logic [2:0]  hsize_i,        // AHB size
  input  wire logic [31:0] hwdata_i,       // AHB write data
  input  wire logic        hready_i,       // AHB bus ready
  output logic      [31:0] hrdata_o,       // AHB read data
  output logic             hreadyout_o,    // AHB slave ready
  output logic             hresp_o,        // AHB response
  input  wire logic        sub_tick_i,     // Sub clock rate tick
  input  wire logic        tmr_match_i,    // Timer match pulse
  input  wire logic        sck_i,          // Serial clock pin in
  output logic             sck_o,          // Serial clock pin out
  output logic             sck_oe_o,       // Serial clock drive enable
  input  wire logic        sdi_i,          // Serial data in pin
  output logic             sdi_ie_o,       // Data input in use
  output logic             sdo_o,          // Serial data out
  output logic             sdo_oe_o,       // Data out drive enable
  input  wire logic        ssn_i,          // Select pin in
  output logic             ssn_o,          // Select pin out
  output logic             ssn_oe_o,       // Select drive enable
  output logic             irq_o           // Transfer complete request
);
  import smp_pkg::*;

  // ****************************************
  // Register bus
  // ****************************************
  logic        ph_wr_reg;
  logic [7:0]  ph_addr_reg;
  logic [7:0]  ctrl0_reg;
  logic [7:0]  ctrl1_reg;
  logic [7:0]  data_reg;
  logic [7:0]  buf_reg;
  logic [3:0]  cnt_reg;
  logic [7:0]  div_reg;
  logic        sck_reg;
  logic        tog_reg;
  logic        sck_in_reg;
  logic        ssn_in_reg;
  logic        sdo_reg;
  logic        ssn_out_reg;
  smp_state_type state_reg;
  smp_role_type  role;
  logic        en;
  logic        pol;
  logic        edg;
  logic        msb;
  logic        csen;
  logic        master;
  logic        slave;
  logic        busy;
  logic        data_wr;
  logic        c0_wr;
  logic        c1_wr;
  logic        done;
  logic        abort;
  logic        tick;
  logic        cap_pol;
  logic        edge_cap;
  logic        edge_lau;
  logic        slv_sel;

  // Byte after one received bit, in the chosen bit order
  function automatic logic [7:0] shift_in(input logic [7:0] b, input logic first_msb,
                                          input logic bit_in);
    return first_msb ? {b[6:0], bit_in} : {bit_in, b[7:1]};
  endfunction

  // Bit of a byte that leaves first, in the chosen bit order
  function automatic logic out_bit(input logic [7:0] b, input logic first_msb);
    return first_msb ? b[7] : b[0];
  endfunction

  assign role    = smp_role_type'(ctrl0_reg[`SMP_C0_ROLE_HI:`SMP_C0_ROLE_LO]);
  assign en      = ctrl0_reg[`SMP_C0_EN] && (role != SMP_ROLE_OFF0) && (role != SMP_ROLE_OFF1);
  assign pol     = ctrl1_reg[`SMP_C1_POL];
  assign edg     = ctrl1_reg[`SMP_C1_EDGE];
  assign msb     = ctrl1_reg[`SMP_C1_MSB];
  assign csen    = ctrl1_reg[`SMP_C1_CSEN];
  assign master  = en && (role != SMP_ROLE_SLAVE);
  assign slave   = en && (role == SMP_ROLE_SLAVE);
  assign busy    = (state_reg != SMP_ST_IDLE);
  assign data_wr = ph_wr_reg && (ph_addr_reg == `SMP_DATA_ADDR);
  assign c0_wr   = ph_wr_reg && (ph_addr_reg == `SMP_CTRL0_ADDR);
  assign c1_wr   = ph_wr_reg && (ph_addr_reg == `SMP_CTRL1_ADDR);

  // Zero wait state, always OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  // Address phase capture
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_wr_reg   <= 1'b0;
      ph_addr_reg <= 8'h00;
    end else if (hready_i) begin
      ph_wr_reg   <= hsel_i && htrans_i[1] && hwrite_i;
      ph_addr_reg <= haddr_i[7:0];
    end
  end

  // Read data registered from address phase
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
      case (haddr_i[7:0])
        `SMP_CTRL0_ADDR: hrdata_o <= {24'h000000, ctrl0_reg};
        `SMP_CTRL1_ADDR: hrdata_o <= {24'h000000, ctrl1_reg};
        `SMP_DATA_ADDR:  hrdata_o <= {24'h000000, data_reg};
        default:         hrdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Control and flags
  // ****************************************
  // Control 0 with incomplete flag; hardware set wins over clear
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl0_reg <= `SMP_CTRL0_RESET;
    end else begin
      if (c0_wr) begin
        ctrl0_reg <= {hwdata_i[7:5], 3'b000, hwdata_i[1:0]};
      end
      if (abort) begin
        ctrl0_reg[`SMP_C0_ICF] <= 1'b1; // RULE_21
      end
    end
  end

  // Control 1 with sticky collision and completion flags
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl1_reg <= `SMP_CTRL1_RESET;
    end else begin
      if (c1_wr) begin
        ctrl1_reg <= {2'b00, hwdata_i[5:0]};
      end
      if (data_wr && busy) begin
        ctrl1_reg[`SMP_C1_WCOL] <= 1'b1; // RULE_17
      end
      if (done || (abort && !(c0_wr && hwdata_i[`SMP_C0_ICF]))) begin
        ctrl1_reg[`SMP_C1_TRF] <= 1'b1; // RULE_02 RULE_21
      end
    end
  end

  // Completion request to the interrupt controller
  assign irq_o = ctrl1_reg[`SMP_C1_TRF]; // RULE_18

  // ****************************************
  // Clock generation and pin sampling
  // ****************************************
  // Master bit clock divider, tick every half period
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg <= 8'h00;
      tog_reg <= 1'b0;
    end else if (state_reg == SMP_ST_IDLE || !master) begin
      div_reg <= 8'h00;
    end else begin
      case (role)
        SMP_ROLE_DIV4:  div_reg <= (div_reg + 8'd1 >= `SMP_DIV4_HALF) ? 8'h00 : div_reg + 8'd1;
        SMP_ROLE_DIV16: div_reg <= (div_reg + 8'd1 >= `SMP_DIV16_HALF) ? 8'h00 : div_reg + 8'd1;
        SMP_ROLE_DIV64: div_reg <= (div_reg + 8'd1 >= `SMP_DIV64_HALF) ? 8'h00 : div_reg + 8'd1;
        SMP_ROLE_TMR: begin
          if (tmr_match_i) begin
            tog_reg <= !tog_reg;
          end
        end
        default: div_reg <= 8'h00;
      endcase
    end
  end

  // One half-period enable for the selected source, RULE_19
  always_comb begin
    case (role)
      SMP_ROLE_DIV4:  tick = (div_reg + 8'd1 >= `SMP_DIV4_HALF); // RULE_19
      SMP_ROLE_DIV16: tick = (div_reg + 8'd1 >= `SMP_DIV16_HALF);
      SMP_ROLE_DIV64: tick = (div_reg + 8'd1 >= `SMP_DIV64_HALF);
      SMP_ROLE_SUB:   tick = sub_tick_i; // RULE_06
      SMP_ROLE_TMR:   tick = tmr_match_i && tog_reg;
      default:        tick = 1'b0;
    endcase
  end

  // Pin sampling for slave edges and select
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_in_reg <= 1'b0;
      ssn_in_reg <= 1'b1;
    end else begin
      sck_in_reg <= sck_i;
      ssn_in_reg <= ssn_i;
    end
  end

  // Capture level: idle high (pol 0) captures rising when edge 0, RULE_20
  assign cap_pol = pol ^ edg; // RULE_20
  assign slv_sel = !csen || !ssn_i; // RULE_10
  assign edge_cap = master ? (tick && (sck_reg == cap_pol))
                           : (slave && slv_sel && (sck_i != sck_in_reg) && (sck_i == !cap_pol));
  assign edge_lau = master ? (tick && (sck_reg != cap_pol))
                           : (slave && slv_sel && (sck_i != sck_in_reg) && (sck_i == cap_pol));
  assign abort = slave && csen && busy && ssn_i && !ssn_in_reg; // RULE_21
  assign done  = busy && edge_cap && (cnt_reg == `SMP_BITS - 4'd1); // RULE_23

  // ****************************************
  // Transfer engine
  // ****************************************
  // Sequence: master lead half-period with select low, then eight bits
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= SMP_ST_IDLE;
      cnt_reg   <= 4'h0;
    end else if (!en || abort) begin
      state_reg <= SMP_ST_IDLE;
      cnt_reg   <= 4'h0;
    end else begin
      case (state_reg)
        SMP_ST_IDLE: begin
          cnt_reg <= 4'h0;
          if (master && data_wr) begin
            state_reg <= SMP_ST_LEAD; // RULE_01 RULE_07 RULE_14
          end else if (slave && edge_cap) begin
            // First capture is taken here; a lone launch edge leaves the port idle
            state_reg <= SMP_ST_SHIFT; // RULE_03
            cnt_reg   <= 4'h1;
          end
        end
        SMP_ST_LEAD: begin
          if (tick) begin
            state_reg <= SMP_ST_SHIFT; // RULE_04
          end
        end
        SMP_ST_SHIFT: begin
          if (edge_cap) begin
            cnt_reg <= cnt_reg + 4'd1;
            if (done) begin
              state_reg <= SMP_ST_IDLE; // RULE_23
            end
          end
        end
        default: state_reg <= SMP_ST_IDLE;
      endcase
    end
  end

  // Master serial clock, idle level from polarity
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_reg <= 1'b1;
    end else if (state_reg != SMP_ST_SHIFT || !master) begin
      sck_reg <= !pol; // RULE_12
    end else if (tick) begin
      // Last capture edge is kept; idle level returns as the port leaves shifting
      sck_reg <= !sck_reg; // RULE_14
    end
  end

  // Shift buffer: captures serial input, loaded by idle writes
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      buf_reg <= 8'h00;
    end else if (data_wr && !busy) begin
      buf_reg <= hwdata_i[7:0]; // RULE_17
    end else if (edge_cap && (state_reg == SMP_ST_SHIFT || slave)) begin
      buf_reg <= shift_in(buf_reg, msb, sdi_i); // RULE_22 RULE_16 RULE_15
    end
  end

  // Readable data register, loaded by idle writes and at word end
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_reg <= 8'h00;
    end else if (data_wr && !busy) begin
      data_reg <= hwdata_i[7:0];
    end else if (done) begin
      data_reg <= shift_in(buf_reg, msb, sdi_i); // RULE_16
    end
  end

  // Outgoing bit: preset before first capture, advanced on launch edges
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sdo_reg <= 1'b1;
    end else if (!busy) begin
      sdo_reg <= (data_wr && en) ? out_bit(hwdata_i[7:0], msb)
               : (slave ? out_bit(buf_reg, msb) : 1'b1); // RULE_05 RULE_11
    end else if (edge_lau && state_reg == SMP_ST_SHIFT && cnt_reg != 4'h0) begin
      sdo_reg <= out_bit(buf_reg, msb); // RULE_03
    end
  end

  // Master select output, low for the whole transfer
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ssn_out_reg <= 1'b1;
    end else begin
      ssn_out_reg <= !(master && (busy || (data_wr && !busy))); // RULE_04
    end
  end

  // ****************************************
  // Pin drive, released when disabled
  // ****************************************
  assign sck_o    = sck_reg;
  assign sck_oe_o = master; // RULE_08 RULE_13 RULE_09
  assign sdo_o    = sdo_reg;
  assign sdo_oe_o = en; // RULE_08 RULE_11
  assign sdi_ie_o = en && busy; // RULE_11
  assign ssn_o    = ssn_out_reg;
  assign ssn_oe_o = master && csen; // RULE_10 RULE_08

  // ****************************************
  // Checks
  // ****************************************
  a_trf_sticky: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE_02
    ctrl1_reg[0] && !c1_wr |=> ctrl1_reg[0]) else $error("completion flag dropped");
  a_done_sets: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE_23
    done |=> ctrl1_reg[0] && state_reg == SMP_ST_IDLE) else $error("done not flagged");
  a_wcol_set: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE_17
    data_wr && busy |=> ctrl1_reg[1] && $stable(buf_reg)) else $error("collision missed");
  a_master_start: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE_01
    master && data_wr && !busy && !abort |=> state_reg == SMP_ST_LEAD) else $error("no start");
  a_sel_first: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE_04
    master && $changed(sck_reg) && state_reg == SMP_ST_SHIFT |-> !ssn_o) else $error("clk before sel");
  a_idle_clock: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE_12
    master && !busy && !$past(busy) && !$changed(pol) |-> sck_o == !pol) else $error("idle level");
  a_released: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE_08
    !en |-> !sck_oe_o && !sdo_oe_o && !ssn_oe_o) else $error("pins not released");
  a_abort_flags: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE_21
    abort && !c1_wr |=> ctrl0_reg[0] && ctrl1_reg[0]) else $error("abort flags");
  a_irq_follow: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE_18
    irq_o == ctrl1_reg[0]) else $error("irq mismatch");
  // Link timing, flag and pin checks
  a_slave_enter: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE_03
    slave && !busy && edge_cap |=> busy && cnt_reg == 4'h1) else $error("slave start");
  a_sel_ignored: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE_10
    !csen |-> !ssn_oe_o && !abort) else $error("select used");
  a_data_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE_16
    busy && !done |=> $stable(data_reg)) else $error("early data update");
  a_idle_out: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE_11
    master && $past(master) && !busy && !$past(busy) && !$past(data_wr) |-> sdo_o && sdo_oe_o)
    else $error("idle data out");
  a_slave_pins: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE_13
    slave |-> !sck_oe_o && !ssn_oe_o) else $error("slave drives clock");
  a_cap_level: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE_20
    master && edge_cap && state_reg == SMP_ST_SHIFT && !c1_wr |=> sck_o == (pol ~^ edg))
    else $error("capture edge level");
  a_lead_sel: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE_07
    state_reg == SMP_ST_LEAD |-> !ssn_o && sck_o == !pol) else $error("lead phase");
  a_bit_count: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE_23
    state_reg == SMP_ST_SHIFT |-> cnt_reg < 4'h8) else $error("bit count");
  a_wcol_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE_17
    ctrl1_reg[1] && !c1_wr |=> ctrl1_reg[1]) else $error("collision flag dropped");
  a_icf_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE_21
    ctrl0_reg[0] && !c0_wr |=> ctrl0_reg[0]) else $error("incomplete flag dropped");
  c_master_done: cover property (@(posedge clock_i) master && done);
  c_slave_done: cover property (@(posedge clock_i) slave && done);
  c_collide: cover property (@(posedge clock_i) data_wr && busy);
  c_abort: cover property (@(posedge clock_i) abort);
  c_cap_first: cover property (@(posedge clock_i) master && edge_cap && edg && cnt_reg == 4'h0);
endmodule
`default_nettype wire

// ===== test/smp_peer.sv
// Far-side serial slave model facing the port in master mode
`timescale 1ns/10ps
`default_nettype none
module smp_peer (
  input  wire logic       sck_i,  // Link clock on the wire
  input  wire logic       ssn_i,  // Select on the wire
  input  wire logic       sdo_i,  // Data from the port
  input  wire logic       rise_i, // Capture on rising edge
  input  wire logic       msb_i,  // Most significant bit first
  input  wire logic [7:0] tx_i,   // Byte sent back
  output logic            sdi_o,  // Data to the port
  output logic      [7:0] rx_o,   // Byte captured
  output logic      [3:0] cnt_o   // Capture edges in frame
);
  // Bit k of a frame in the chosen order
  function automatic logic pick(input logic [7:0] b, input logic [3:0] k);
    return msb_i ? b[3'd7 - k[2:0]] : b[k[2:0]];
  endfunction
  initial begin
    sdi_o = 1'b0;
    rx_o = 8'h00;
    cnt_o = 4'h0;
  end
  // First bit stands before the first capture edge
  always @(negedge ssn_i) begin
    cnt_o = 4'h0;
    sdi_o = pick(tx_i, 4'h0);
  end
  // Deselected line no longer shows the last bit
  always @(posedge ssn_i) sdi_o = ~sdi_o;
  // Capture on the active edge, launch the next bit on the other
  always @(sck_i) begin
    if (!ssn_i && cnt_o < 4'h8) begin
      if (sck_i === rise_i) begin
        rx_o[msb_i ? 3'd7 - cnt_o[2:0] : cnt_o[2:0]] = sdo_i;
        cnt_o = cnt_o + 4'h1;
      end else if (cnt_o != 4'h0) begin
        sdi_o = pick(tx_i, cnt_o);
      end
    end
  end
endmodule
`default_nettype wire

// ===== test/test_smp_port.sv
// Self-checking bench for the serial port: bus tasks and link scenarios
`timescale 1ns/10ps
`default_nettype none
module test_smp_port;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic        sub_tick = 1'b0;
  logic        tmr = 1'b0;
  logic [1:0]  sc = 2'b00;
  logic        b_sck = 1'b1;
  logic        b_ssn = 1'b1;
  logic        b_sdi = 1'b0;
  logic        slv = 1'b0;
  logic        rise = 1'b0;
  logic        msb = 1'b0;
  logic [7:0]  ptx = 8'h00;
  logic [31:0] hrdata;
  logic [7:0]  prx;
  logic [3:0]  pcnt;
  logic        hready, hresp, sck_o, sck_oe, sdi_ie, sdo, sdo_oe, ssn_o, ssn_oe, irq, psdi;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          gap = 0;
  int          k = 0;
  time         t1 = 0;
  wire logic   sck_w = sck_oe ? sck_o : b_sck;
  wire logic   ssn_w = ssn_oe ? ssn_o : b_ssn;
  wire logic   sdi_w = slv ? b_sdi : psdi;

  // ****************
  // Clock, ticks, monitors
  // ****************
  always #25 clock_i = ~clock_i;
  // Sub-clock tick every third cycle, timer match every second
  always @(posedge clock_i) begin
    sc <= (sc == 2'd2) ? 2'd0 : sc + 2'd1;
    sub_tick <= (sc == 2'd2);
    tmr <= ~tmr;
  end
  // Spacing of the first two link clock edges of a master frame
  always @(sck_o) begin
    if (!ssn_o && sck_oe) begin
      k = k + 1;
      if (k == 1) t1 = $time;
      if (k == 2) gap = int'(($time - t1) / 50);
    end
  end
  always @(negedge ssn_o) k = 0;

  smp_port DUT (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .sub_tick_i(sub_tick), .tmr_match_i(tmr), .sck_i(sck_w), .sck_o(sck_o),
    .sck_oe_o(sck_oe), .sdi_i(sdi_w), .sdi_ie_o(sdi_ie), .sdo_o(sdo),
    .sdo_oe_o(sdo_oe), .ssn_i(ssn_w), .ssn_o(ssn_o), .ssn_oe_o(ssn_oe), .irq_o(irq)
  );
  smp_peer peer (
    .sck_i(sck_w), .ssn_i(ssn_w), .sdo_i(sdo), .rise_i(rise), .msb_i(msb),
    .tx_i(ptx), .sdi_o(psdi), .rx_o(prx), .cnt_o(pcnt)
  );

  // ****************
  // Tasks
  // ****************
  task automatic final_report();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One single word transfer, address phase then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clock_i);
    while (hready !== 1'b1) @(posedge clock_i);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clock_i);
    while (hready !== 1'b1) @(posedge clock_i);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    ahb(1'b1, a, {24'h0, d}, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk(q, {24'h0, e});
  endtask
  // Poll the completion flag; the watchdog ends a hang
  task automatic wait_done();
    logic [31:0] q;
    q = 32'h0;
    while (q[0] !== 1'b1) ahb(1'b0, 8'h04, 32'h0, q);
  endtask
  task automatic settle();
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
  endtask
  // Master frame: c1 holds polarity, edge, bit order
  task automatic mxfer(input logic [2:0] role, input logic [2:0] c1, input logic [7:0] tx,
                       input logic [7:0] pb, input int half, input logic col);
    slv = 1'b0;
    rise = (c1[2] == c1[1]);
    msb = c1[0];
    ptx = pb;
    wr(8'h00, {role, 5'h00});
    wr(8'h04, {2'b00, c1, 3'b100});
    wr(8'h00, {role, 5'h02});
    settle();
    chk(32'({sck_oe, sck_o, sdo}), 32'({1'b1, ~c1[2], 1'b1}));
    @(posedge clock_i);
    wr(8'h08, tx);
    if (col) begin
      wr(8'h08, 8'h3c);
      rd(8'h04, {2'b00, c1, 3'b110});
    end
    wait_done();
    chk(32'(irq), 32'h1);
    rd(8'h08, pb);
    chk(32'(prx), 32'(tx));
    chk(32'(pcnt), 32'h8);
    chk(32'(gap), 32'(half));
    rd(8'h04, {2'b00, c1, 1'b1, col, 1'b1});
    wr(8'h04, {2'b00, c1, 3'b100});
    rd(8'h04, {2'b00, c1, 3'b100});
    chk(32'(irq), 32'h0);
  endtask
  // Slave frame of nb bits, idle high, capture on falling edge, MSB first
  task automatic sxfer(input logic [7:0] tx, input logic [7:0] rb, input int nb);
    logic [7:0] got;
    got = 8'h00;
    slv = 1'b1;
    wr(8'h00, 8'ha0);
    wr(8'h04, 8'h1c);
    wr(8'h00, 8'ha2);
    wr(8'h08, tx);
    b_ssn <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      b_sdi <= rb[7 - i];
      repeat (4) @(posedge clock_i);
      got[7 - i] = sdo;
      b_sck <= 1'b0;
      repeat (4) @(posedge clock_i);
      b_sck <= 1'b1;
      repeat (4) @(posedge clock_i);
    end
    b_ssn <= 1'b1;
    b_sdi <= ~rb[8 - nb];
    repeat (4) @(posedge clock_i);
    if (nb == 8) begin
      chk(32'(got), 32'(tx));
      rd(8'h08, rb);
      rd(8'h00, 8'ha2);
    end else begin
      rd(8'h08, tx);
      rd(8'h00, 8'ha3);
    end
    rd(8'h04, 8'h1d);
    wr(8'h00, 8'ha2);
    wr(8'h04, 8'h1c);
  endtask

  // ****************
  // Sequence and watchdog
  // ****************
  initial begin
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    chk(32'({sck_oe, sdo_oe, ssn_oe, irq, hresp}), 32'h0);
    rd(8'h00, 8'he0);
    rd(8'h04, 8'h00);
    rd(8'h0c, 8'h00);
    mxfer(3'b000, 3'b000, 8'h96, 8'h5a, 2, 1'b0);
    mxfer(3'b001, 3'b011, 8'hc3, 8'h81, 8, 1'b0);
    mxfer(3'b010, 3'b101, 8'h0f, 8'hf0, 32, 1'b1);
    mxfer(3'b011, 3'b110, 8'h2d, 8'hb4, 3, 1'b0);
    mxfer(3'b100, 3'b001, 8'h71, 8'h8e, 4, 1'b0);
    sxfer(8'ha5, 8'h3b, 8);
    sxfer(8'h69, 8'hff, 3);
    wr(8'h00, 8'h02);
    wr(8'h04, 8'h00);
    settle();
    chk(32'(ssn_oe), 32'h0);
    @(posedge clock_i);
    wr(8'h00, 8'he0);
    settle();
    chk(32'({sck_oe, sdo_oe, ssn_oe, sdi_ie}), 32'h0);
    final_report();
  end
  initial begin
    repeat (40000) @(posedge clock_i);
    error_cnt++;
    final_report();
  end
endmodule
`default_nettype wire
